// *** tpr_regs.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - both pin selects zero: pin is pen interrupt AND data-available
// - source select one: pin carries data-available active low
// - format one, source zero: pin carries pen interrupt only
// - filter control bits reset to zero; zero bypasses filter
// - while filter gathers, busy shown on converter busy output if filter bits nonzero
// - filter control bits read back as written
// - zone codes: off, below low, between, above high
// - zone enabled: store and flag only when criterion met
// - zone disabled: always store and flag
// - aux/temp averaged per enable bit before zone check
// - bits 9:8 temp zone, 7:6 aux zone, reset zero
// - bits 4:0 enable filter for X, Y, Z, AUX, TEMP
// - function bit 13 X drivers on, bit 14 Y drivers on
// - driver bits clear on complete, stop, or reset
// - function bits 12:0 one-hot of running function code
// - one-hot clears on end, except scan codes in self-scan mode ended by completion, not stop
// - status 15:9 data flags, set on store, clear when read
// - status bit 7 zero after reset until polled, then one
// - status 6,5 connection pass; bit 3 no Y short
// - status bit 2 follows power-down ctl while clock active or synchronised pen level low
// - status 1:0 version identifier
// - status resets to 0006h; bits 8 and 4 read zero
// - soft reset held by host bit; device never clears it
module tpr_regs (
   input wire logic i_mclk,
   input wire logic i_reset,
   // register port from serial interface
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   // soft reset held by control byte
   input wire logic i_ctrl1_soft_reset,
   // converter sequencer
   input wire logic i_func_start,
   input wire logic [3:0] i_function_code,
   input wire logic i_func_done,
   input wire logic i_stop_status_bit,
   input wire logic i_self_scan_select,
   input wire logic i_x_drv_on,
   input wire logic i_y_drv_on,
   input wire logic i_filter_busy,
   input wire tpr_pkg::tpr_result_type i_result,
   input wire tpr_pkg::tpr_test_type i_test,
   input wire logic i_adc_powerdown_ctl,
   input wire logic i_clk_active,
   // pen touch and pin
   input wire logic i_pen_touch_irq_n,
   output logic o_irq_data_pin,
   output logic [11:0] o_stored_value,
   output logic o_store,
   output logic o_converter_busy,
   output logic [15:0] o_preproc_config
);
   import tpr_pkg::*;

   logic rst;
   logic [15:0] cfg_r, cfg_nxt;
   logic [15:0] func_r, func_nxt;
   logic [TPR_NUM_DATA-1:0] dav_r, dav_nxt;
   logic rstflag_r, rstflag_nxt;
   logic powerdown_state_r, powerdown_state_nxt;
   tpr_test_type test_r, test_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic pin_r, pin_nxt;
   logic [11:0] val_r, val_nxt;
   logic store_r, store_nxt;
   logic busy_r, busy_nxt;
   logic pen_s1_r, pen_s2_r;
   logic accept;
   logic [1:0] zone_sel;
   logic dav_any;
   logic [15:0] status_word;
   logic [15:0] onehot_v;

   assign rst = i_reset | i_ctrl1_soft_reset;

   function automatic logic [15:0] tpr_onehot(input logic [3:0] code);
      logic [15:0] v;
      v = '0;
      if (code < 4'(TPR_NUM_FUNC))
         v[code] = 1'b1;
      return v;
   endfunction : tpr_onehot

   always_comb begin
      if (i_result.chan == TPR_CH_AUX) begin
         zone_sel = cfg_r[TPR_CFG_AZ_HI:TPR_CFG_AZ_LO];
      end else if (i_result.chan == TPR_CH_TEMP1 || i_result.chan == TPR_CH_TEMP2) begin
         zone_sel = cfg_r[TPR_CFG_TZ_HI:TPR_CFG_TZ_LO];
      end else begin
         zone_sel = TPR_ZONE_OFF;
      end
   end

   // result arrives already averaged per enable bits, so zone check follows the filter
   tpr_zone_check u_zone (
      .i_zone_sel(zone_sel),
      .i_value(i_result.value),
      .i_thr_lo(i_result.thr_lo),
      .i_thr_hi(i_result.thr_hi),
      .o_accept(accept)
   );

   assign dav_any = |dav_r;

   always_comb begin
      status_word = '0;
      status_word[15:9] = {dav_r[0], dav_r[1], dav_r[2], dav_r[3],
                           dav_r[4], dav_r[5], dav_r[6]};
      status_word[7] = rstflag_r;
      status_word[6] = test_r.x_connected;
      status_word[5] = test_r.y_connected;
      status_word[3] = test_r.y_no_short;
      status_word[2] = powerdown_state_r;
      status_word[1:0] = TPR_VERSION_ID;
   end

   // configuration register
   always_comb begin
      cfg_nxt = cfg_r;
      if (i_reg_wr && i_reg_addr == TPR_ADDR_PREPROC)
         cfg_nxt = i_reg_wdata & TPR_PREPROC_WMASK;
   end

   // function run status
   always_comb begin
      onehot_v = tpr_onehot(i_function_code);
      func_nxt = func_r;
      func_nxt[TPR_FUNC_XDRV] = i_x_drv_on;
      func_nxt[TPR_FUNC_YDRV] = i_y_drv_on;
      if (i_func_start)
         func_nxt[TPR_NUM_FUNC-1:0] = onehot_v[TPR_NUM_FUNC-1:0];
      if (i_func_done || i_stop_status_bit) begin
         func_nxt[TPR_FUNC_XDRV] = 1'b0;
         func_nxt[TPR_FUNC_YDRV] = 1'b0;
         // scan codes stay armed so the next touch restarts without the host
         if (i_self_scan_select && !i_stop_status_bit &&
             (func_r[TPR_FC_XYZ] || func_r[TPR_FC_XY])) begin
            func_nxt[TPR_NUM_FUNC-1:0] = func_r[TPR_NUM_FUNC-1:0];
         end else begin
            func_nxt[TPR_NUM_FUNC-1:0] = '0;
         end
      end
   end

   // data flags, reset flag and status bits
   always_comb begin
      dav_nxt = dav_r;
      store_nxt = 1'b0;
      val_nxt = val_r;
      if (i_reg_rd && i_reg_addr < 4'(TPR_NUM_DATA))
         dav_nxt[i_reg_addr[2:0]] = 1'b0;
      if (i_result.valid && accept) begin
         dav_nxt[i_result.chan] = 1'b1; // set wins over clear
         store_nxt = 1'b1;
         val_nxt = i_result.value;
      end
      rstflag_nxt = rstflag_r;
      if (i_reg_rd && i_reg_addr == TPR_ADDR_STATUS)
         rstflag_nxt = 1'b1;
      powerdown_state_nxt = powerdown_state_r;
      // synchronised pen level only; the raw pin is asynchronous
      if (i_clk_active || pen_s2_r == 1'b0)
         powerdown_state_nxt = i_adc_powerdown_ctl;
      test_nxt = i_test;
      // filter gathering keeps converter busy, data flags not yet set
      busy_nxt = i_filter_busy && (cfg_r[TPR_CFG_FILT_HI:TPR_CFG_FILT_LO] != '0);
   end

   // read mux and pin
   always_comb begin
      unique case (i_reg_addr)
         TPR_ADDR_STATUS: rdata_nxt = status_word;
         TPR_ADDR_PREPROC: rdata_nxt = cfg_r;
         TPR_ADDR_FUNC: rdata_nxt = func_r;
         default: rdata_nxt = rdata_r;
      endcase
      if (cfg_r[TPR_CFG_SRC]) begin
         pin_nxt = ~dav_any;
      end else if (cfg_r[TPR_CFG_FMT]) begin
         pin_nxt = pen_s2_r;
      end else begin
         pin_nxt = pen_s2_r & dav_any;
      end
   end

   always_ff @(posedge i_mclk) begin
      pen_s1_r <= i_pen_touch_irq_n;
      pen_s2_r <= pen_s1_r;
      if (rst) begin
         cfg_r <= TPR_PREPROC_RESET;
         func_r <= TPR_FUNC_RESET;
         dav_r <= '0;
         rstflag_r <= 1'b0;
         powerdown_state_r <= TPR_STATUS_RESET[2];
         test_r <= '0;
         rdata_r <= '0;
         pin_r <= 1'b1;
         val_r <= '0;
         store_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         func_r <= func_nxt;
         dav_r <= dav_nxt;
         rstflag_r <= rstflag_nxt;
         powerdown_state_r <= powerdown_state_nxt;
         test_r <= test_nxt;
         rdata_r <= rdata_nxt;
         pin_r <= pin_nxt;
         val_r <= val_nxt;
         store_r <= store_nxt;
         busy_r <= busy_nxt;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (rst) begin
         o_preproc_config <= TPR_PREPROC_RESET;
      end else begin
         o_preproc_config <= cfg_nxt;
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_irq_data_pin = pin_r;
   assign o_stored_value = val_r;
   assign o_store = store_r;
   assign o_converter_busy = busy_r;
endmodule : tpr_regs

// *** tpr_pkg.sv ***
package tpr_pkg;
   // register addresses on the internal register port
   localparam logic [3:0] TPR_ADDR_X = 4'h0;
   localparam logic [3:0] TPR_ADDR_STATUS = 4'h7;
   localparam logic [3:0] TPR_ADDR_PREPROC = 4'he;
   localparam logic [3:0] TPR_ADDR_FUNC = 4'hf;
   localparam int TPR_NUM_DATA = 7;
   localparam logic [15:0] TPR_PREPROC_RESET = 16'h0000;
   localparam logic [15:0] TPR_PREPROC_WMASK = 16'hffdf;
   localparam logic [15:0] TPR_FUNC_RESET = 16'h0000;
   localparam logic [15:0] TPR_STATUS_RESET = 16'h0004;
   // field positions in the configuration and function words, with function, zone and channel codes
   localparam int TPR_CFG_FMT = 15;
   localparam int TPR_CFG_SRC = 14;
   localparam int TPR_CFG_FILT_HI = 13;
   localparam int TPR_CFG_FILT_LO = 10;
   localparam int TPR_CFG_TZ_HI = 9;
   localparam int TPR_CFG_TZ_LO = 8;
   localparam int TPR_CFG_AZ_HI = 7;
   localparam int TPR_CFG_AZ_LO = 6;
   localparam int TPR_CFG_FEN_HI = 4;
   localparam int TPR_FUNC_XDRV = 13;
   localparam int TPR_FUNC_YDRV = 14;
   localparam int TPR_NUM_FUNC = 13;
   localparam logic [3:0] TPR_FC_XYZ = 4'h0;
   localparam logic [3:0] TPR_FC_XY = 4'h1;
   localparam logic [1:0] TPR_ZONE_OFF = 2'h0;
   localparam logic [1:0] TPR_ZONE_BELOW = 2'h1;
   localparam logic [1:0] TPR_ZONE_BETWEEN = 2'h2;
   localparam logic [1:0] TPR_ZONE_ABOVE = 2'h3;
   localparam logic [2:0] TPR_CH_AUX = 3'h4;
   localparam logic [2:0] TPR_CH_TEMP1 = 3'h5;
   localparam logic [2:0] TPR_CH_TEMP2 = 3'h6;
   // version id, value arbitrary
   localparam logic [1:0] TPR_VERSION_ID = 2'h2;

   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [11:0] value;
      logic [11:0] thr_lo;
      logic [11:0] thr_hi;
   } tpr_result_type;

   typedef struct packed {
      logic x_connected;
      logic y_connected;
      logic y_no_short;
   } tpr_test_type;
endpackage : tpr_pkg

// *** tpr_zone_check.sv ***
`timescale 1ns/100ps
module tpr_zone_check (
   // zone select and result
   input wire logic [1:0] i_zone_sel,
   input wire logic [11:0] i_value,
   input wire logic [11:0] i_thr_lo,
   input wire logic [11:0] i_thr_hi,
   // verdict
   output logic o_accept
);
   import tpr_pkg::*;
   always_comb begin
      unique case (i_zone_sel)
         TPR_ZONE_OFF: o_accept = 1'b1;
         TPR_ZONE_BELOW: o_accept = i_value < i_thr_lo;
         TPR_ZONE_BETWEEN: o_accept = (i_value >= i_thr_lo) && (i_value <= i_thr_hi);
         TPR_ZONE_ABOVE: o_accept = i_value > i_thr_hi;
      endcase
   end
endmodule : tpr_zone_check

// *** tpr_regs_asserts.sv ***
`timescale 1ns/100ps
module tpr_regs_asrt (
   // clock and resets
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ctrl1_soft_reset,
   // register port
   input wire logic i_reg_wr,
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   // sequencer side
   input wire logic i_filter_busy,
   input wire tpr_pkg::tpr_result_type i_result,
   input wire logic i_pen_touch_irq_n,
   input wire logic o_irq_data_pin,
   input wire logic [11:0] o_stored_value,
   input wire logic o_store,
   input wire logic o_converter_busy,
   input wire logic [15:0] o_preproc_config
);
   import tpr_pkg::*;
   wire logic [15:0] cfg = o_preproc_config;
   wire logic sr = i_ctrl1_soft_reset;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   a_cfg_reset: assert property ($fell(i_reset) |-> cfg == 16'h0000)
      else $error("config not cleared by reset");
   a_soft_clear: assert property (sr |=> cfg == 16'h0000)
      else $error("config kept during soft reset");
   a_cfg_write: assert property (i_reg_wr && i_reg_addr == 4'he && !sr
      |=> cfg == ($past(i_reg_wdata) & 16'hffdf))
      else $error("config write not taken");
   // pen input passes two sync stages and the pin flop, so four samples settle it
   a_pin_pen_only: assert property ((cfg[15:14] == 2'b10 && !i_pen_touch_irq_n)[*4]
      |-> !o_irq_data_pin)
      else $error("pin does not follow pen touch");
   a_store_direct: assert property (i_result.valid && i_result.chan < 3'h4 && !sr
      |=> o_store && o_stored_value == $past(i_result.value))
      else $error("result not stored");
   a_zone_below: assert property (cfg[9:8] == 2'h1 && i_result.valid && i_result.chan == 3'h5
      && i_result.value >= i_result.thr_lo |=> !o_store)
      else $error("rejected result stored");
   a_busy_filter: assert property (i_filter_busy && cfg[13:10] != 4'h0 && !sr
      |=> o_converter_busy)
      else $error("busy missing while filtering");
   a_status_rsvd: assert property ($past(i_reg_addr) == 4'h7
      |-> o_reg_rdata[8] == 1'b0 && o_reg_rdata[4] == 1'b0)
      else $error("reserved status bit set");
   c_store: cover property (o_store);
   c_src_sel: cover property (cfg[15:14] == 2'b01);
   c_busy: cover property (o_converter_busy);
endmodule : tpr_regs_asrt

bind tpr_regs tpr_regs_asrt u_asrt (.*);

// *** tpr_host_model.sv ***
`timescale 1ns/100ps
module tpr_host_model (
   // clock
   input wire logic i_mclk,
   // register port toward the device
   output logic o_wr,
   output logic o_rd,
   output logic [3:0] o_addr,
   output logic [15:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 4'h0;
      o_wdata = 16'h0000;
   end
   // strobe held one edge; idle data inverted so a stale word is never mistaken
   task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      #1;
      o_wr = w;
      o_rd = !w;
      o_addr = a;
      o_wdata = d;
      @(posedge i_mclk);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = ~d;
   endtask : access
endmodule : tpr_host_model

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import tpr_pkg::*;
   logic i_mclk = 1'b0, i_reset = 1'b1, i_ctrl1_soft_reset = 1'b0, i_func_start = 1'b0;
   logic i_func_done = 1'b0, i_stop_status_bit = 1'b0, i_self_scan_select = 1'b0;
   logic i_x_drv_on = 1'b0, i_y_drv_on = 1'b0, i_filter_busy = 1'b0;
   logic i_adc_powerdown_ctl = 1'b0, i_clk_active = 1'b0, i_pen_touch_irq_n = 1'b1;
   logic i_reg_wr, i_reg_rd, o_irq_data_pin, o_store, o_converter_busy, rd_seen = 1'b0;
   logic [3:0] i_reg_addr, i_function_code = 4'h0;
   logic [15:0] i_reg_wdata, o_reg_rdata, o_preproc_config, r;
   logic [11:0] o_stored_value, v;
   logic [16:0] n, rq[$];
   logic [11:0] sq[$];
   tpr_result_type i_result = '0;
   tpr_test_type i_test = 3'b101;
   int fail_count = 0, compares = 0, seed = 32'h382c5fae;
   always #12.5 i_mclk = ~i_mclk;
   tpr_regs dut (.*);
   tpr_host_model host (.i_mclk(i_mclk), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
      .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic report_and_stop;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   function automatic logic [15:0] st(input logic [6:0] f, input logic rf, input logic pd);
      return {f, 1'b0, rf, i_test[2:1], 1'b0, i_test[0], pd, TPR_VERSION_ID};
   endfunction : st
   task automatic rd_reg(input logic [3:0] a, input logic c, input logic [15:0] e);
      rq.push_back({c, e});
      host.access(1'b0, a, 16'h0000);
   endtask : rd_reg
   task automatic pulse(ref logic s);
      @(posedge i_mclk);
      #1;
      s = 1'b1;
      @(posedge i_mclk);
      #1;
      s = 1'b0;
   endtask : pulse
   task automatic result(input logic [2:0] ch, input logic [11:0] val, input logic ok);
      if (ok) sq.push_back(val);
      @(posedge i_mclk);
      #1;
      i_result = '{1'b1, ch, val, 12'h100, 12'h300};
      @(posedge i_mclk);
      #1;
      i_result.valid = 1'b0;
   endtask : result
   task automatic pin_is(input logic e);
      repeat (4) @(posedge i_mclk);
      cmp({15'h0, o_irq_data_pin}, {15'h0, e});
   endtask : pin_is
   // read data answers the address of the previous edge, stores come one edge late
   always @(posedge i_mclk) begin
      if (rd_seen) begin
         n = rq.pop_front();
         if (n[16]) cmp(o_reg_rdata, n[15:0]);
      end
      if (o_store) cmp({4'h0, o_stored_value}, sq.size() ? {4'h0, sq.pop_front()} : 16'hf000);
      rd_seen <= i_reg_rd;
   end
   initial begin
      repeat (5000) @(posedge i_mclk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge i_mclk);
      #1;
      i_reset = 1'b0;
      rd_reg(4'h7, 1'b1, st(7'h00, 1'b0, 1'b1));
      rd_reg(4'h7, 1'b1, st(7'h00, 1'b1, 1'b1));
      rd_reg(4'he, 1'b1, 16'h0000);
      rd_reg(4'hf, 1'b1, 16'h0000);
      host.access(1'b1, 4'h7, 16'hffff);
      rd_reg(4'h7, 1'b1, st(7'h00, 1'b1, 1'b1));
      for (int k = 0; k < 4; k++) begin
         r = k ? 16'($random(seed)) : 16'hffff;
         host.access(1'b1, 4'he, r);
         rd_reg(4'he, 1'b1, r & 16'hffdf);
      end
      for (int c = 0; c < 13; c++) begin
         i_function_code = c[3:0];
         pulse(i_func_start);
         {i_y_drv_on, i_x_drv_on} = c[1:0];
         rd_reg(4'hf, 1'b1, (16'h1 << c) | {1'b0, c[1:0], 13'h0});
         {i_y_drv_on, i_x_drv_on} = 2'b00;
         pulse(i_func_done);
         rd_reg(4'hf, 1'b1, 16'h0000);
      end
      i_self_scan_select = 1'b1;
      i_function_code = 4'h1;
      pulse(i_func_start);
      pulse(i_func_done);
      rd_reg(4'hf, 1'b1, 16'h0002);
      pulse(i_stop_status_bit);
      rd_reg(4'hf, 1'b1, 16'h0000);
      result(3'h0, 12'h123, 1'b1);
      for (int z = 0; z < 4; z++) begin
         host.access(1'b1, 4'he, {6'h00, z[1:0], 2'(z + 1), 6'h00});
         for (int k = 0; k < 3; k++) begin
            v = (z + k) % 3 == 0 ? 12'h050 : (z + k) % 3 == 1 ? 12'h200 : 12'h500;
            r[1:0] = k ? z[1:0] : 2'(z + 1);
            result(3'(4 + k), v, r[1:0] == 2'h0 || r[1:0] == 2'((z + k) % 3 + 1));
         end
      end
      rd_reg(4'h7, 1'b1, st(7'b1000111, 1'b1, 1'b1));
      rd_reg(4'h0, 1'b0, 16'h0000);
      rd_reg(4'h7, 1'b1, st(7'b0000111, 1'b1, 1'b1));
      host.access(1'b1, 4'he, 16'h4000);
      pin_is(1'b0);
      host.access(1'b1, 4'he, 16'h0000);
      pin_is(1'b1);
      host.access(1'b1, 4'he, 16'h8000);
      i_pen_touch_irq_n = 1'b0;
      pin_is(1'b0);
      i_pen_touch_irq_n = 1'b1;
      host.access(1'b1, 4'he, 16'h3c1f);
      i_filter_busy = 1'b1;
      repeat (3) @(posedge i_mclk);
      cmp({15'h0, o_converter_busy}, 16'h0001);
      #1;
      i_filter_busy = 1'b0;
      pulse(i_ctrl1_soft_reset);
      rd_reg(4'he, 1'b1, 16'h0000);
      rd_reg(4'h7, 1'b1, st(7'h00, 1'b0, 1'b1));
      i_clk_active = 1'b1;
      repeat (3) @(posedge i_mclk);
      rd_reg(4'h7, 1'b1, st(7'h00, 1'b1, 1'b0));
      repeat (3) @(posedge i_mclk);
      report_and_stop();
   end
endmodule : testbench
